// *** rtl/count_clock_divider.sv ***
// divide-by-4 and divide-by-12 count enable pulses from the oscillator clock
`timescale 1ns/100ps
`default_nettype none
module count_clock_divider (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // one-cycle enables
  output logic fastTick,
  output logic slowTick
);
  localparam logic [3:0] LAST_SLOW = 4'(timer_unit_pkg::DIV_SLOW - 1);
  localparam logic [3:0] FAST_MASK = 4'(timer_unit_pkg::DIV_FAST - 1);

  logic [timer_unit_pkg::DIV_CNT_W-1:0] phase;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase <= '0;
    end else if (phase == LAST_SLOW) begin
      phase <= '0;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // 12 is a multiple of 4, so both pulses stay evenly spaced
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fastTick <= 1'b0;
      slowTick <= 1'b0;
    end else begin
      fastTick <= (phase & FAST_MASK) == FAST_MASK;
      slowTick <= phase == LAST_SLOW;
    end
  end
endmodule
`default_nettype wire

// *** rtl/dual_timer_counter_unit.sv ***
// two timer/counters with external interrupt detect flags behind the sfr bus
// Functional notes
// - unimplemented register locations read back as ones; spare bits in implemented registers read back as written.
// - single-bit set/clear works on addresses whose low digit is 0 or 8.
// - overflow flags set on overflow, cleared on vectoring, software writable.
// - run bits written by software; a timer counts only while run is one.
// - detect flags set by edge/level; vector clears edge only; level follows pin.
// - type bits pick falling-edge or low-level triggering per interrupt pin.
// - with gating set, counting also needs the interrupt pin high.
// - counter-select chooses divided clock or falling edges on the count pin.
// - mode 0 is an 8-bit counter behind a 5-bit prescaler.
// - mode 1 is one 16-bit counter over both bytes.
// - mode 2 reloads the low byte from the high byte on overflow.
// - timer 0 mode 3 splits; high byte runs under timer 1 controls.
// - timer 1 in mode 3 halts and keeps its count.
// - clock-select bits pick oscillator divided by 4 or by 12.
// - timers and interrupt detection keep running while the core idles.
`timescale 1ns/100ps
`default_nettype none
module dual_timer_counter_unit (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // special function register bus
  input wire logic [7:0] sfrAddr,
  input wire logic sfrRdEn,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrBitWrEn,
  input wire logic [2:0] sfrBitSel,
  input wire logic sfrBitVal,
  output logic [7:0] sfrRdData,
  // vectoring acknowledges from the interrupt controller
  input wire logic timer0Vectored,
  input wire logic timer1Vectored,
  input wire logic extIrq0Vectored,
  input wire logic extIrq1Vectored,
  // pins
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  input wire logic timer0CountPin,
  input wire logic timer1CountPin,
  // flags to the interrupt controller
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag,
  output logic ext_irq0_detect_flag,
  output logic ext_irq1_detect_flag,
  // clock select for timer 2 outside this block
  output logic timer2_fast_clock
);
  // byte after a byte write or single-bit write to the given address
  function automatic logic [7:0] writeByte(input logic [7:0] old,
                                           input logic [7:0] target);
    logic [7:0] r;
    r = old;
    if (sfrWrEn && sfrAddr == target) begin
      r = sfrWrData;
    end else if (sfrBitWrEn && sfrAddr == target && bitAddressable(target)) begin
      r[sfrBitSel] = sfrBitVal;
    end
    return r;
  endfunction

  function automatic logic bitAddressable(input logic [7:0] a);
    return a[3:0] == timer_unit_pkg::BIT_ADDR_DIGIT_A ||
           a[3:0] == timer_unit_pkg::BIT_ADDR_DIGIT_B;
  endfunction

  // one count step: {overflow, high, low}
  function automatic logic [16:0] countStep(input logic [1:0] mode,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi);
    logic [16:0] r;
    logic [8:0] s;
    logic [5:0] p;
    r = {1'b0, hi, lo};
    s = '0;
    p = '0;
    unique case (mode)
      timer_unit_pkg::MODE_PRESCALE: begin
        // upper three low-byte bits are left alone
        p = {1'b0, lo[timer_unit_pkg::PRESCALE_BITS-1:0]} + 6'h01;
        r[4:0] = p[4:0];
        if (p[5]) begin
          s = {1'b0, hi} + 9'h001;
          r[15:8] = s[7:0];
          r[16] = s[8];
        end
      end
      timer_unit_pkg::MODE_WIDE: begin
        r = {1'b0, hi, lo} + 17'h0_0001;
      end
      timer_unit_pkg::MODE_RELOAD: begin
        s = {1'b0, lo} + 9'h001;
        r[7:0] = s[8] ? hi : s[7:0];
        r[16] = s[8];
      end
      timer_unit_pkg::MODE_SPLIT: begin
        s = {1'b0, lo} + 9'h001;
        r[7:0] = s[7:0];
        r[16] = s[8];
      end
    endcase
    return r;
  endfunction

  // register state
  logic timer0_run_bit;
  logic timer1_run_bit;
  logic ext_irq0_trigger_type;
  logic ext_irq1_trigger_type;
  logic [7:0] timer_mode_config;
  logic [7:0] timer0_count_low;
  logic [7:0] timer0_count_high;
  logic [7:0] timer1_count_low;
  logic [7:0] timer1_count_high;
  logic [7:0] clock_divider_select;
  logic [7:0] flagsView;
  logic [7:0] flagsNext;
  // pin history for falling-edge detection
  logic irq0Prev;
  logic irq1Prev;
  logic cnt0Prev;
  logic cnt1Prev;
  // count enables
  logic fastTick;
  logic slowTick;
  logic t0DivTick;
  logic t1DivTick;
  logic t0Source;
  logic t1Source;
  logic t0Enable;
  logic t1Enable;
  logic t0HighEnable;
  logic [1:0] t0Mode;
  logic [1:0] t1Mode;
  logic t0Split;
  logic [16:0] t0Step;
  logic [16:0] t1Step;
  logic [8:0] t0HighStep;
  logic t0Overflow;
  logic t1Overflow;
  logic t0HighOverflow;
  logic irq0Event;
  logic irq1Event;

  // free-running divider; nothing here depends on the core clock gating
  count_clock_divider divider (
    .ref_clk(ref_clk),
    .rst(rst),
    .fastTick(fastTick),
    .slowTick(slowTick)
  );

  assign t0Mode = timer_mode_config[timer_unit_pkg::MC_T0_MODE_HI:
                                    timer_unit_pkg::MC_T0_MODE_LO];
  assign t1Mode = timer_mode_config[timer_unit_pkg::MC_T1_MODE_HI:
                                    timer_unit_pkg::MC_T1_MODE_LO];
  assign t0Split = t0Mode == timer_unit_pkg::MODE_SPLIT;

  assign t0DivTick = clock_divider_select[timer_unit_pkg::CS_T0_FAST] ?
                     fastTick : slowTick;
  assign t1DivTick = clock_divider_select[timer_unit_pkg::CS_T1_FAST] ?
                     fastTick : slowTick;

  // counter mode takes high-to-low transitions of the count pin
  assign t0Source = timer_mode_config[timer_unit_pkg::MC_T0_COUNTER] ?
                    (cnt0Prev & ~timer0CountPin) : t0DivTick;
  assign t1Source = timer_mode_config[timer_unit_pkg::MC_T1_COUNTER] ?
                    (cnt1Prev & ~timer1CountPin) : t1DivTick;

  assign t0Enable = timer0_run_bit && t0Source &&
                    (!timer_mode_config[timer_unit_pkg::MC_T0_GATE] ||
                     ext_irq0_pin);
  assign t1Enable = timer1_run_bit && t1Source &&
                    (!timer_mode_config[timer_unit_pkg::MC_T1_GATE] ||
                     ext_irq1_pin) &&
                    t1Mode != timer_unit_pkg::MODE_SPLIT;
  // split high byte is a pure timer on timer 1's run bit
  assign t0HighEnable = t0Split && timer1_run_bit && t1DivTick;

  assign t0Step = countStep(t0Mode, timer0_count_low, timer0_count_high);
  assign t1Step = countStep(t1Mode, timer1_count_low, timer1_count_high);
  assign t0HighStep = {1'b0, timer0_count_high} + 9'h001;
  assign t0Overflow = t0Enable && t0Step[16];
  assign t0HighOverflow = t0HighEnable && t0HighStep[8];
  // while timer 0 is split, timer 1 keeps counting but its flag belongs to timer 0
  assign t1Overflow = t1Enable && t1Step[16] && !t0Split;

  assign irq0Event = ext_irq0_trigger_type ? (irq0Prev & ~ext_irq0_pin)
                                           : ~ext_irq0_pin;
  assign irq1Event = ext_irq1_trigger_type ? (irq1Prev & ~ext_irq1_pin)
                                           : ~ext_irq1_pin;

  assign flagsView = {timer1_overflow_flag, timer1_run_bit,
                      timer0_overflow_flag, timer0_run_bit,
                      ext_irq1_detect_flag, ext_irq1_trigger_type,
                      ext_irq0_detect_flag, ext_irq0_trigger_type};
  // writeByte reads the bus strobes itself, which a continuous assign would not wake on
  always_comb flagsNext = writeByte(flagsView, timer_unit_pkg::ADDR_FLAGS_CONTROL);

  // pin history; pins are synchronous to ref_clk
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq0Prev <= 1'b1;
      irq1Prev <= 1'b1;
      cnt0Prev <= 1'b1;
      cnt1Prev <= 1'b1;
    end else begin
      irq0Prev <= ext_irq0_pin;
      irq1Prev <= ext_irq1_pin;
      cnt0Prev <= timer0CountPin;
      cnt1Prev <= timer1CountPin;
    end
  end

  // run and type bits are software only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer1_run_bit <= timer_unit_pkg::RESET_FLAGS_CONTROL[timer_unit_pkg::FC_T1_RUN];
      timer0_run_bit <= timer_unit_pkg::RESET_FLAGS_CONTROL[timer_unit_pkg::FC_T0_RUN];
      ext_irq1_trigger_type <=
        timer_unit_pkg::RESET_FLAGS_CONTROL[timer_unit_pkg::FC_IRQ1_TYPE];
      ext_irq0_trigger_type <=
        timer_unit_pkg::RESET_FLAGS_CONTROL[timer_unit_pkg::FC_IRQ0_TYPE];
    end else begin
      timer1_run_bit <= flagsNext[timer_unit_pkg::FC_T1_RUN];
      timer0_run_bit <= flagsNext[timer_unit_pkg::FC_T0_RUN];
      ext_irq1_trigger_type <= flagsNext[timer_unit_pkg::FC_IRQ1_TYPE];
      ext_irq0_trigger_type <= flagsNext[timer_unit_pkg::FC_IRQ0_TYPE];
    end
  end

  // overflow flags: hardware set beats a clear from software or vectoring
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer1_overflow_flag <= timer_unit_pkg::RESET_FLAGS_CONTROL[timer_unit_pkg::FC_T1_OVF];
      timer0_overflow_flag <= timer_unit_pkg::RESET_FLAGS_CONTROL[timer_unit_pkg::FC_T0_OVF];
    end else begin
      if (t1Overflow || t0HighOverflow) begin
        timer1_overflow_flag <= 1'b1;
      end else if (timer1Vectored) begin
        timer1_overflow_flag <= 1'b0;
      end else begin
        timer1_overflow_flag <= flagsNext[timer_unit_pkg::FC_T1_OVF];
      end
      if (t0Overflow) begin
        timer0_overflow_flag <= 1'b1;
      end else if (timer0Vectored) begin
        timer0_overflow_flag <= 1'b0;
      end else begin
        timer0_overflow_flag <= flagsNext[timer_unit_pkg::FC_T0_OVF];
      end
    end
  end

  // detect flags; in level mode the flag is the inverted pin and software writes are lost
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ext_irq1_detect_flag <= timer_unit_pkg::RESET_FLAGS_CONTROL[timer_unit_pkg::FC_IRQ1_DET];
      ext_irq0_detect_flag <= timer_unit_pkg::RESET_FLAGS_CONTROL[timer_unit_pkg::FC_IRQ0_DET];
    end else begin
      if (!ext_irq1_trigger_type) begin
        ext_irq1_detect_flag <= ~ext_irq1_pin;
      end else if (irq1Event) begin
        ext_irq1_detect_flag <= 1'b1;
      end else if (extIrq1Vectored) begin
        ext_irq1_detect_flag <= 1'b0;
      end else begin
        ext_irq1_detect_flag <= flagsNext[timer_unit_pkg::FC_IRQ1_DET];
      end
      if (!ext_irq0_trigger_type) begin
        ext_irq0_detect_flag <= ~ext_irq0_pin;
      end else if (irq0Event) begin
        ext_irq0_detect_flag <= 1'b1;
      end else if (extIrq0Vectored) begin
        ext_irq0_detect_flag <= 1'b0;
      end else begin
        ext_irq0_detect_flag <= flagsNext[timer_unit_pkg::FC_IRQ0_DET];
      end
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer_mode_config <= timer_unit_pkg::RESET_MODE_CONFIG;
      clock_divider_select <= timer_unit_pkg::RESET_CLOCK_SELECT;
      timer2_fast_clock <= timer_unit_pkg::RESET_CLOCK_SELECT[timer_unit_pkg::CS_T2_FAST];
    end else begin
      timer_mode_config <= writeByte(timer_mode_config,
                                     timer_unit_pkg::ADDR_MODE_CONFIG);
      clock_divider_select <= writeByte(clock_divider_select,
                                        timer_unit_pkg::ADDR_CLOCK_SELECT);
      timer2_fast_clock <= clock_divider_select[timer_unit_pkg::CS_T2_FAST];
    end
  end

  // timer 0 count; a software write wins over a count step in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer0_count_low <= timer_unit_pkg::RESET_COUNT;
      timer0_count_high <= timer_unit_pkg::RESET_COUNT;
    end else begin
      if (sfrWrEn && sfrAddr == timer_unit_pkg::ADDR_T0_LOW) begin
        timer0_count_low <= sfrWrData;
      end else if (t0Enable) begin
        timer0_count_low <= t0Step[7:0];
      end
      if (sfrWrEn && sfrAddr == timer_unit_pkg::ADDR_T0_HIGH) begin
        timer0_count_high <= sfrWrData;
      end else if (t0Split) begin
        if (t0HighEnable) begin
          timer0_count_high <= t0HighStep[7:0];
        end
      end else if (t0Enable) begin
        timer0_count_high <= t0Step[15:8];
      end
    end
  end

  // timer 1 count; mode 3 clears its enable, so the count holds
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer1_count_low <= timer_unit_pkg::RESET_COUNT;
      timer1_count_high <= timer_unit_pkg::RESET_COUNT;
    end else begin
      if (sfrWrEn && sfrAddr == timer_unit_pkg::ADDR_T1_LOW) begin
        timer1_count_low <= sfrWrData;
      end else if (t1Enable) begin
        timer1_count_low <= t1Step[7:0];
      end
      if (sfrWrEn && sfrAddr == timer_unit_pkg::ADDR_T1_HIGH) begin
        timer1_count_high <= sfrWrData;
      end else if (t1Enable) begin
        timer1_count_high <= t1Step[15:8];
      end
    end
  end

  // registered read data, one cycle after the read strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sfrRdData <= timer_unit_pkg::RESET_READ_DATA;
    end else if (sfrRdEn) begin
      unique case (sfrAddr)
        timer_unit_pkg::ADDR_FLAGS_CONTROL: sfrRdData <= flagsView;
        timer_unit_pkg::ADDR_MODE_CONFIG: sfrRdData <= timer_mode_config;
        timer_unit_pkg::ADDR_T0_LOW: sfrRdData <= timer0_count_low;
        timer_unit_pkg::ADDR_T1_LOW: sfrRdData <= timer1_count_low;
        timer_unit_pkg::ADDR_T0_HIGH: sfrRdData <= timer0_count_high;
        timer_unit_pkg::ADDR_T1_HIGH: sfrRdData <= timer1_count_high;
        timer_unit_pkg::ADDR_CLOCK_SELECT: sfrRdData <= clock_divider_select;
        default: sfrRdData <= timer_unit_pkg::UNIMPLEMENTED_READ;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** rtl/timer_unit_pkg.sv ***
// constants shared by the dual timer/counter unit
package timer_unit_pkg;
  // special function register addresses
  localparam logic [7:0] ADDR_FLAGS_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_MODE_CONFIG = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW = 8'h8a;
  localparam logic [7:0] ADDR_T1_LOW = 8'h8b;
  localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
  localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;
  localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h8e;
  // low address digits that allow single-bit access
  localparam logic [3:0] BIT_ADDR_DIGIT_A = 4'h0;
  localparam logic [3:0] BIT_ADDR_DIGIT_B = 4'h8;
  // value returned for anything not implemented
  localparam logic [7:0] UNIMPLEMENTED_READ = 8'hff;
  // flags-and-run control fields
  localparam int FC_T1_OVF = 7;
  localparam int FC_T1_RUN = 6;
  localparam int FC_T0_OVF = 5;
  localparam int FC_T0_RUN = 4;
  localparam int FC_IRQ1_DET = 3;
  localparam int FC_IRQ1_TYPE = 2;
  localparam int FC_IRQ0_DET = 1;
  localparam int FC_IRQ0_TYPE = 0;
  // mode register fields; timer 1 upper nibble, timer 0 lower nibble
  localparam int MC_T1_GATE = 7;
  localparam int MC_T1_COUNTER = 6;
  localparam int MC_T1_MODE_HI = 5;
  localparam int MC_T1_MODE_LO = 4;
  localparam int MC_T0_GATE = 3;
  localparam int MC_T0_COUNTER = 2;
  localparam int MC_T0_MODE_HI = 1;
  localparam int MC_T0_MODE_LO = 0;
  // clock select fields
  localparam int CS_T2_FAST = 5;
  localparam int CS_T1_FAST = 4;
  localparam int CS_T0_FAST = 3;
  // count mode codes
  localparam logic [1:0] MODE_PRESCALE = 2'h0;
  localparam logic [1:0] MODE_WIDE = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam int PRESCALE_BITS = 5;
  // count clock divisors
  localparam int DIV_FAST = 4;
  localparam int DIV_SLOW = 12;
  localparam int DIV_CNT_W = 4;
  // reset values
  localparam logic [7:0] RESET_FLAGS_CONTROL = 8'h00;
  localparam logic [7:0] RESET_MODE_CONFIG = 8'h00;
  localparam logic [7:0] RESET_COUNT = 8'h00;
  localparam logic [7:0] RESET_CLOCK_SELECT = 8'h01;
  localparam logic [7:0] RESET_READ_DATA = 8'hff;
endpackage

// *** tb/dual_timer_counter_unit_tb_top.sv ***
// self-checking bench for the dual timer/counter unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module dual_timer_counter_unit_tb_top;
  logic ref_clk, rst, sfrRdEn, sfrWrEn, sfrBitWrEn, sfrBitVal, t2Fast;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, rdv, want;
  logic [2:0] sfrBitSel;
  logic [3:0] vec;
  logic [1:0] irqPin, cntPin, ovf, det;
  int n_mismatch = 0, n_tests = 0, cyc = 0, t, m, g, p, lo, hi, n, en, f, c;
  integer seed;
  sfr_core_model sfr_core_model_i (.ref_clk(ref_clk), .sfrAddr(sfrAddr), .sfrRdEn(sfrRdEn),
    .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrBitWrEn(sfrBitWrEn),
    .sfrBitSel(sfrBitSel), .sfrBitVal(sfrBitVal), .sfrRdData(sfrRdData));
  dual_timer_counter_unit dual_timer_counter_unit_i (.ref_clk(ref_clk), .rst(rst),
    .sfrAddr(sfrAddr), .sfrRdEn(sfrRdEn), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
    .sfrBitWrEn(sfrBitWrEn), .sfrBitSel(sfrBitSel), .sfrBitVal(sfrBitVal),
    .sfrRdData(sfrRdData), .timer0Vectored(vec[0]), .timer1Vectored(vec[1]),
    .extIrq0Vectored(vec[2]), .extIrq1Vectored(vec[3]), .ext_irq0_pin(irqPin[0]),
    .ext_irq1_pin(irqPin[1]), .timer0CountPin(cntPin[0]), .timer1CountPin(cntPin[1]),
    .timer0_overflow_flag(ovf[0]), .timer1_overflow_flag(ovf[1]),
    .ext_irq0_detect_flag(det[0]), .ext_irq1_detect_flag(det[1]), .timer2_fast_clock(t2Fast));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic vecPulse(input int i);
    vec[i] = 1'b1;
    tick(1);
    vec[i] = 1'b0;
  endtask
  // count pin held low then high for two cycles each so every fall is seen
  task automatic pulse(input int i, input int k);
    repeat (k) begin
      cntPin[i] = 1'b0;
      tick(2);
      cntPin[i] = 1'b1;
      tick(2);
    end
  endtask
  task automatic waitOvf(output int k);
    k = 0;
    do begin
      tick(1);
      k++;
    end while (ovf[0] !== 1'b1 && k < 2000);
  endtask
  initial begin
    seed = 78328;
    rst = 1'b1;
    vec = 4'h0;
    irqPin = 2'b11;
    cntPin = 2'b11;
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    for (int a = 8'h86; a <= 8'h8f; a++) begin
      sfr_core_model_i.rd(8'(a), rdv);
      want = (a == 8'h8e) ? 8'h01 : (a >= 8'h88 && a <= 8'h8d) ? 8'h00 : 8'hff;
      `CHK(rdv, want)
    end
    for (int a = 8'h89; a <= 8'h8e; a++) begin
      want = 8'($random(seed));
      sfr_core_model_i.wr(8'(a), want);
      sfr_core_model_i.rd(8'(a), rdv);
      `CHK(rdv, want)
    end
    `CHK(t2Fast, want[5])
    sfr_core_model_i.bwr(8'h8e, 3'h0, ~want[0]);
    sfr_core_model_i.rd(8'h8e, rdv);
    `CHK(rdv, want)
    // every mode on both timers, counted from the pins with random gating
    for (int r = 0; r < 16; r++) begin
      t = r % 2;
      m = (r / 2) % 4;
      g = $random(seed) & 1;
      p = $random(seed) & 1;
      lo = $random(seed) & 255;
      hi = $random(seed) & 255;
      n = 1 + {$random(seed)} % 40;
      sfr_core_model_i.wr(8'h88, 8'h00);
      sfr_core_model_i.wr(8'h89, 8'((g * 8 + 4 + m) << (4 * t)));
      sfr_core_model_i.wr(8'(8'h8a + t), 8'(lo));
      sfr_core_model_i.wr(8'(8'h8c + t), 8'(hi));
      irqPin = 2'(p * 3);
      sfr_core_model_i.bwr(8'h88, 3'(4 + 2 * t), 1'b1);
      pulse(t, n);
      sfr_core_model_i.bwr(8'h88, 3'(4 + 2 * t), 1'b0);
      en = (g == 0 || p == 1) && !(t == 1 && m == 3);
      f = 0;
      for (int k = 0; k < n && en; k++) begin
        case (m)
          0: begin
            c = ((hi << 5) | (lo & 31)) + 1;
            f |= (c >> 13) & 1;
            hi = (c >> 5) & 255;
            lo = (lo & 224) | (c & 31);
          end
          1: begin
            c = ((hi << 8) | lo) + 1;
            f |= (c >> 16) & 1;
            hi = (c >> 8) & 255;
            lo = c & 255;
          end
          2: begin
            lo++;
            if (lo == 256) begin
              lo = hi;
              f = 1;
            end
          end
          default: begin
            lo = (lo + 1) & 255;
            f |= (lo == 0);
          end
        endcase
      end
      sfr_core_model_i.rd(8'(8'h8a + t), rdv);
      `CHK(rdv, 8'(lo))
      sfr_core_model_i.rd(8'(8'h8c + t), rdv);
      `CHK(rdv, 8'(hi))
      `CHK(ovf[t], 1'(f))
      vecPulse(t);
      `CHK(ovf[t], 1'b0)
    end
    for (int i = 0; i < 2; i++) begin
      irqPin = 2'b11;
      sfr_core_model_i.bwr(8'h88, 3'(2 * i), 1'b1);
      irqPin[i] = 1'b0;
      tick(2);
      `CHK(det[i], 1'b1)
      irqPin[i] = 1'b1;
      tick(2);
      `CHK(det[i], 1'b1)
      vecPulse(2 + i);
      `CHK(det[i], 1'b0)
      sfr_core_model_i.bwr(8'h88, 3'(2 * i), 1'b0);
      irqPin[i] = 1'b0;
      tick(2);
      vecPulse(2 + i);
      `CHK(det[i], 1'b1)
      irqPin[i] = 1'b1;
      tick(2);
      `CHK(det[i], 1'b0)
    end
    // reload period from the divided clock, slow then fast
    for (int s = 0; s < 2; s++) begin
      sfr_core_model_i.wr(8'h88, 8'h00);
      sfr_core_model_i.wr(8'h89, 8'h02);
      sfr_core_model_i.wr(8'h8e, 8'(s * 8));
      sfr_core_model_i.wr(8'h8a, 8'h80);
      sfr_core_model_i.wr(8'h8c, 8'h80);
      sfr_core_model_i.bwr(8'h88, 3'h4, 1'b1);
      waitOvf(n);
      vecPulse(0);
      waitOvf(n);
      `CHK(n + 1, 128 * (s ? 4 : 12))
    end
    // split high byte runs on timer 1's run bit and fast clock, and flags timer 1
    sfr_core_model_i.wr(8'h89, 8'h03);
    sfr_core_model_i.wr(8'h8e, 8'h10);
    sfr_core_model_i.wr(8'h8c, 8'hff);
    sfr_core_model_i.wr(8'h88, 8'h40);
    tick(4);
    `CHK(ovf, 2'h2)
    close_out();
  end
endmodule
`default_nettype wire

// *** tb/sfr_core_model.sv ***
// processor core model driving the special function register bus
`timescale 1ns/100ps
`default_nettype none
module sfr_core_model (
  // clock
  input wire logic ref_clk,
  // register bus
  output logic [7:0] sfrAddr,
  output logic sfrRdEn,
  output logic sfrWrEn,
  output logic [7:0] sfrWrData,
  output logic sfrBitWrEn,
  output logic [2:0] sfrBitSel,
  output logic sfrBitVal,
  input wire logic [7:0] sfrRdData
);
  initial begin
    {sfrAddr, sfrRdEn, sfrWrEn, sfrWrData, sfrBitWrEn, sfrBitSel, sfrBitVal} = '0;
  end
  // one request, launched after an edge and taken at the next one
  task automatic go(input logic [7:0] a, input logic [2:0] k, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    {sfrRdEn, sfrWrEn, sfrBitWrEn} = k;
    sfrAddr = a;
    sfrWrData = d;
    sfrBitSel = d[2:0];
    sfrBitVal = d[3];
    @(posedge ref_clk);
    #1;
    {sfrRdEn, sfrWrEn, sfrBitWrEn} = 3'h0;
    // released lines keep moving so a stale decode cannot pass
    sfrAddr = ~a;
    sfrWrData = ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    go(a, 3'h2, d);
  endtask
  // software sets and clears run and type bits one at a time
  task automatic bwr(input logic [7:0] a, input logic [2:0] s, input logic v);
    go(a, 3'h1, {4'h0, v, s});
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    go(a, 3'h4, 8'h00);
    d = sfrRdData;
  endtask
endmodule
`default_nettype wire

// *** tb/timer_unit_chk.sv ***
// assertion checker for the dual timer/counter unit
`timescale 1ns/100ps
`default_nettype none
module timer_unit_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register bus
  input wire logic [7:0] sfrAddr,
  input wire logic sfrRdEn,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrBitWrEn,
  input wire logic [2:0] sfrBitSel,
  input wire logic sfrBitVal,
  input wire logic [7:0] sfrRdData,
  // vectors, pins and flags
  input wire logic timer0Vectored,
  input wire logic timer1Vectored,
  input wire logic extIrq0Vectored,
  input wire logic ext_irq0_pin,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic ext_irq0_detect_flag,
  input wire logic timer2_fast_clock
);
  logic [7:0] ctl;
  logic wrCtl;
  assign wrCtl = (sfrWrEn || sfrBitWrEn) && sfrAddr == timer_unit_pkg::ADDR_FLAGS_CONTROL;
  // mirror of the control byte; only the run and type bits are relied on
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl <= 8'h00;
    end else if (sfrWrEn && wrCtl) begin
      ctl <= sfrWrData;
    end else if (wrCtl) begin
      ctl[sfrBitSel] <= sfrBitVal;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence clkSelWrite;
    sfrWrEn && sfrAddr == 8'h8e ##1 !(sfrWrEn && sfrAddr == 8'h8e);
  endsequence
  sequence edgeVector;
    ctl[0] && extIrq0Vectored && !wrCtl && !$fell(ext_irq0_pin);
  endsequence
  unmapped_read_a: assert property (sfrRdEn && (sfrAddr < 8'h88 || sfrAddr > 8'h8e)
    |=> sfrRdData == 8'hff) else $error("unmapped read not all ones");
  level_follow_a: assert property (!ctl[0]
    |=> ext_irq0_detect_flag == !$past(ext_irq0_pin)) else $error("level flag not pin");
  edge_set_a: assert property (ctl[0] && !wrCtl && $fell(ext_irq0_pin)
    |=> ext_irq0_detect_flag) else $error("falling edge not flagged");
  edge_vector_a: assert property (edgeVector |=> !ext_irq0_detect_flag)
    else $error("edge flag not cleared by vector");
  t0_vector_a: assert property (timer0Vectored && !ctl[4] && !wrCtl
    |=> !timer0_overflow_flag) else $error("timer 0 flag not cleared");
  t1_vector_a: assert property (timer1Vectored && !ctl[6] && !wrCtl
    |=> !timer1_overflow_flag) else $error("timer 1 flag not cleared");
  flag_hold_a: assert property (timer0_overflow_flag && !timer0Vectored && !wrCtl
    |=> timer0_overflow_flag) else $error("timer 0 flag dropped");
  stopped_timer_a: assert property (!timer0_overflow_flag && !ctl[4] && !wrCtl
    |=> !timer0_overflow_flag) else $error("stopped timer 0 overflowed");
  fast_copy_a: assert property (clkSelWrite
    |=> timer2_fast_clock == $past(sfrWrData[5], 2)) else $error("timer 2 select wrong");
  run_readback_a: assert property (sfrRdEn && sfrAddr == 8'h88 && !wrCtl
    |=> sfrRdData[6] == ctl[6] && sfrRdData[4] == ctl[4]) else $error("run bits misread");
endmodule
bind dual_timer_counter_unit timer_unit_chk timer_unit_chk_i (.ref_clk, .rst, .sfrAddr,
  .sfrRdEn, .sfrWrEn, .sfrWrData, .sfrBitWrEn, .sfrBitSel, .sfrBitVal, .sfrRdData,
  .timer0Vectored, .timer1Vectored, .extIrq0Vectored, .ext_irq0_pin, .timer0_overflow_flag,
  .timer1_overflow_flag, .ext_irq0_detect_flag, .timer2_fast_clock);
`default_nettype wire
